// [eblpt_defs.svh]
`ifndef EBLPT_DEFS_SVH
`define EBLPT_DEFS_SVH

// Register byte addresses
`define EBLPT_TIMER_OFS        32'h0001d35c
`define EBLPT_PROGRESS_OFS     32'h0001d3b8
`define EBLPT_CFG_STATUS_OFS   32'h0001d3bc

// Progress register fields
`define EBLPT_CNT_LSB          16
`define EBLPT_PTR_LSB          0
`define EBLPT_PROGRESS_RESET   32'h00000000

// Configuration status fields
`define EBLPT_ACTIVE_BIT       31
`define EBLPT_INHIBIT_BIT      30
`define EBLPT_WIDTH_BIT        29
`define EBLPT_PAGE_BIT         28
`define EBLPT_DEVADDR_LSB      0

// Timer register fields
`define EBLPT_FREERUN_BIT      31
`define EBLPT_TCOUNT_LSB       0

// Chain pointer alignment
`define EBLPT_PTR_ALIGN_MASK   16'hfff8

// Timing
`define EBLPT_CLK_NS           20
`define EBLPT_TICK_NS          1000000
`define EBLPT_TICK_CYCLES      ((`EBLPT_TICK_NS + `EBLPT_CLK_NS - 1) / `EBLPT_CLK_NS)
`define EBLPT_BOOT_TIMEOUT_S   4
`define EBLPT_TICKS_PER_S      1000
`define EBLPT_TIMER_RESET      16'h0fa0

`endif

// [eblpt_pkg.sv]
`include "eblpt_defs.svh"

package eblpt_pkg;

   typedef enum logic [4:0] {
      ST_IDLE       = 5'b00001,
      ST_CNT_HI     = 5'b00010,
      ST_CNT_LO     = 5'b00100,
      ST_PAIRS      = 5'b01000,
      ST_CHAIN_WAIT = 5'b10000
   } eblpt_state_t;

   typedef logic [15:0] eblpt_word16_t;

   function automatic logic [31:0] eblpt_place(input logic [31:0] value, input int lsb);
      eblpt_place = value << lsb;
   endfunction : eblpt_place

endpackage : eblpt_pkg

// [eblpt_timeout_timer.sv]
`timescale 1ns/1ns
`include "eblpt_defs.svh"

module eblpt_timeout_timer
   import eblpt_pkg::*;
#(
   parameter int TICK_CYCLES = `EBLPT_TICK_CYCLES
) (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        loadEn,
   input  wire logic [15:0] loadCount,
   input  wire logic        loadFreeRun,
   input  wire logic        clearEn,
   output logic      [15:0] period,
   output logic      [15:0] remaining,
   output logic             freeRun,
   output logic             expired
);

   localparam int PW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

   logic [PW-1:0] tick_q;
   logic          run_q;
   wire           tickDone = (tick_q == PW'(TICK_CYCLES - 1));
   wire           lastTick = run_q && tickDone && (remaining == 16'h0001);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_q    <= '0;
         run_q     <= 1'b1;
         period    <= `EBLPT_TIMER_RESET;
         remaining <= `EBLPT_TIMER_RESET;
         freeRun   <= 1'b0;
         expired   <= 1'b0;
      end else begin
         expired <= lastTick && !clearEn && !loadEn;
         if (clearEn) begin
            // Completion disables the timer
            tick_q    <= '0;
            run_q     <= 1'b0;
            period    <= 16'h0000;
            remaining <= 16'h0000;
         end else if (loadEn) begin
            // A write restarts without raising the event
            tick_q    <= '0;
            run_q     <= (loadCount != 16'h0000);
            period    <= loadCount;
            remaining <= loadCount;
            freeRun   <= loadFreeRun;
         end else if (lastTick) begin
            tick_q    <= '0;
            run_q     <= freeRun;
            remaining <= freeRun ? period : 16'h0000;
         end else if (run_q && tickDone) begin
            tick_q    <= '0;
            remaining <= remaining - 16'h0001;
         end else if (run_q) begin
            tick_q    <= tick_q + PW'(1);
         end
      end
   end

endmodule : eblpt_timeout_timer

// [eblpt_tracker.sv]
`timescale 1ns/1ns
`include "eblpt_defs.svh"


module eblpt_tracker
   import eblpt_pkg::*;
#(
   parameter int TICK_CYCLES = `EBLPT_TICK_CYCLES
) (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        bootStart,
   input  wire logic        inhibitPin,
   input  wire logic        ctrlPointerWidth,
   input  wire logic        ctrlPageStep,
   input  wire logic  [6:0] ctrlDevAddr,
   input  wire logic        chainReq,
   input  wire logic [15:0] chainAddr,
   input  wire logic        chainPending,
   input  wire logic        byteValid,
   input  wire logic  [7:0] byteData,
   input  wire logic        pairDone,
   output logic             bootActive,
   output logic             bootTimedOut
);

   ////////////////////////////////////////////////////////////////////////////////
   // State

   eblpt_state_t  state_q;
   eblpt_state_t  state_d;
   eblpt_word16_t regsRemaining_q;
   eblpt_word16_t regsRemaining_d;
   logic  [7:0]   countHigh_q;
   eblpt_word16_t pointer_q;
   eblpt_word16_t pointer_d;
   logic  [6:0]   devAddr_q;
   logic  [6:0]   devAddr_d;
   logic          bootActive_q;
   logic          started_q;
   logic          loadInhibited_q;
   logic          pointerWidthSel_q;
   logic          pageStepOn_q;
   logic [31:0]   prdata_q;
   logic          pready_q;
   logic          pslverr_q;

   logic [15:0]   timerPeriod;
   logic [15:0]   timerRemaining;
   logic          timerFreeRun;
   logic          timerExpired;

   ////////////////////////////////////////////////////////////////////////////////
   // Sequence decode

   wire           startOk    = bootStart && !started_q && !loadInhibited_q && (state_q == ST_IDLE);
   wire           abortNow   = timerExpired && bootActive_q;
   wire           chainOk    = chainReq && bootActive_q && !abortNow;
   wire [15:0]    loadedCnt  = {countHigh_q, byteData};
   wire           cntLoad    = (state_q == ST_CNT_LO) && byteValid && !chainOk;
   wire           pairStep   = (state_q == ST_PAIRS) && pairDone && !chainOk && (regsRemaining_q != 16'h0000);
   wire           emptyFile  = cntLoad && (loadedCnt == 16'h0000);
   wire           lastPair   = pairStep && (regsRemaining_q == 16'h0001);
   wire           countEnds  = emptyFile || lastPair;
   wire           finishNow  = countEnds && !chainPending && !abortNow;
   wire           byteStep   = bootActive_q && byteValid && !chainOk;
   wire           pageWrap   = byteStep && pageStepOn_q && (pointer_q[7:0] == 8'hff);
   wire           captureCfg = startOk || chainOk;

   // Pointer is cleared by reset and moves per byte; a chain realigns it
   assign pointer_d = chainOk  ? (chainAddr & `EBLPT_PTR_ALIGN_MASK) :
                      byteStep ? (pointer_q + 16'h0001) :
                                 pointer_q;

   assign regsRemaining_d = cntLoad  ? loadedCnt :
                            pairStep ? (regsRemaining_q - 16'h0001) :
                                       regsRemaining_q;

   // Device address steps on a page wrap only with page increment on
   assign devAddr_d = captureCfg ? ctrlDevAddr :
                      pageWrap   ? (devAddr_q + 7'h01) :
                                   devAddr_q;

   always_comb begin
      state_d = state_q;
      if (abortNow) begin
         state_d = ST_IDLE;
      end else if (chainOk) begin
         state_d = ST_CNT_HI;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (startOk) begin
                  state_d = ST_CNT_HI;
               end
            end
            ST_CNT_HI: begin
               if (byteValid) begin
                  state_d = ST_CNT_LO;
               end
            end
            ST_CNT_LO: begin
               if (byteValid) begin
                  state_d = emptyFile ? (chainPending ? ST_CHAIN_WAIT : ST_IDLE) : ST_PAIRS;
               end
            end
            ST_PAIRS: begin
               if (lastPair) begin
                  state_d = chainPending ? ST_CHAIN_WAIT : ST_IDLE;
               end
            end
            ST_CHAIN_WAIT: begin
               state_d = ST_CHAIN_WAIT;
            end
            default: begin
               state_d = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q         <= ST_IDLE;
         regsRemaining_q <= 16'h0000;
         countHigh_q     <= 8'h00;
         pointer_q       <= 16'h0000;
         devAddr_q       <= 7'h00;
      end else begin
         state_q         <= state_d;
         regsRemaining_q <= regsRemaining_d;
         pointer_q       <= pointer_d;
         devAddr_q       <= devAddr_d;
         if ((state_q == ST_CNT_HI) && byteValid && !chainOk) begin
            countHigh_q <= byteData;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Status flags

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bootActive_q      <= 1'b0;
         started_q         <= 1'b0;
         loadInhibited_q   <= 1'b0;
         pointerWidthSel_q <= 1'b0;
         pageStepOn_q      <= 1'b0;
      end else begin
         loadInhibited_q <= inhibitPin;
         if (startOk) begin
            bootActive_q <= 1'b1;
            started_q    <= 1'b1;
         end else if (finishNow || abortNow) begin
            bootActive_q <= 1'b0;
         end
         if (bootStart) begin
            started_q <= 1'b1;
         end
         if (captureCfg) begin
            pointerWidthSel_q <= ctrlPointerWidth;
            pageStepOn_q      <= ctrlPageStep;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Timeout timer

   wire   apbSetup   = psel && !penable;
   wire   apbAccess  = psel && penable && pready_q;
   wire   hitTimer   = (paddr == `EBLPT_TIMER_OFS);
   wire   hitProg    = (paddr == `EBLPT_PROGRESS_OFS);
   wire   hitCfg     = (paddr == `EBLPT_CFG_STATUS_OFS);
   wire   hitAny     = hitTimer || hitProg || hitCfg;
   wire   timerWrite = apbAccess && pwrite && hitTimer;

   eblpt_timeout_timer #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_timer (
      .core_clk    (core_clk),
      .rst_n       (rst_n),
      .loadEn      (timerWrite),
      .loadCount   (pwdata[`EBLPT_TCOUNT_LSB +: 16]),
      .loadFreeRun (pwdata[`EBLPT_FREERUN_BIT]),
      .clearEn     (finishNow),
      .period      (timerPeriod),
      .remaining   (timerRemaining),
      .freeRun     (timerFreeRun),
      .expired     (timerExpired)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // APB slave

   wire [31:0] progWord  = eblpt_place({16'h0000, regsRemaining_q}, `EBLPT_CNT_LSB) |
                           eblpt_place({16'h0000, pointer_q}, `EBLPT_PTR_LSB);
   wire [31:0] cfgWord   = eblpt_place({31'h0, bootActive_q}, `EBLPT_ACTIVE_BIT) |
                           eblpt_place({31'h0, loadInhibited_q}, `EBLPT_INHIBIT_BIT) |
                           eblpt_place({31'h0, pointerWidthSel_q}, `EBLPT_WIDTH_BIT) |
                           eblpt_place({31'h0, pageStepOn_q}, `EBLPT_PAGE_BIT) |
                           eblpt_place({25'h0, devAddr_q}, `EBLPT_DEVADDR_LSB);
   wire [31:0] timerWord = eblpt_place({31'h0, timerFreeRun}, `EBLPT_FREERUN_BIT) |
                           eblpt_place({16'h0000, timerPeriod}, `EBLPT_TCOUNT_LSB);
   wire [31:0] readWord  = hitProg  ? progWord :
                           hitCfg   ? cfgWord :
                           hitTimer ? timerWord :
                                      32'h00000000;

   // Read data is sampled in the setup cycle; access is always one cycle
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_q  <= `EBLPT_PROGRESS_RESET;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= apbSetup;
         pslverr_q <= apbSetup && !hitAny;
         if (apbSetup) begin
            prdata_q <= pwrite ? 32'h00000000 : readWord;
         end
      end
   end

   assign prdata       = prdata_q;
   assign pready       = pready_q;
   assign pslverr      = pslverr_q;
   assign bootActive   = bootActive_q;
   assign bootTimedOut = timerExpired;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   chk_count_load: assert property (
      cntLoad |=> regsRemaining_q == $past(loadedCnt))
      else $error("count not loaded from header bytes");

   chk_count_step: assert property (
      pairStep |=> regsRemaining_q == $past(regsRemaining_q) - 16'h0001)
      else $error("count did not drop after a pair");

   chk_count_hold: assert property (
      !byteValid && !pairDone |=> $stable(regsRemaining_q))
      else $error("count moved without a read");

   chk_ptr_chain: assert property (
      chainOk |=> pointer_q == ($past(chainAddr) & `EBLPT_PTR_ALIGN_MASK) && pointer_q[2:0] == 3'b000)
      else $error("chain pointer not aligned load");

   chk_ptr_step: assert property (
      byteStep |=> pointer_q == $past(pointer_q) + 16'h0001)
      else $error("pointer did not step per byte");

   chk_active_start: assert property (
      startOk |=> bootActive_q && state_q == ST_CNT_HI)
      else $error("boot start not flagged");

   chk_active_end: assert property (
      (finishNow || abortNow) |=> !bootActive_q && state_q == ST_IDLE)
      else $error("boot end not flagged");

   chk_active_state: assert property (
      bootActive_q == (state_q != ST_IDLE))
      else $error("active flag disagrees with sequence");

   chk_width_capture: assert property (
      captureCfg |=> pointerWidthSel_q == $past(ctrlPointerWidth) && pageStepOn_q == $past(ctrlPageStep))
      else $error("config not captured at start or chain");

   chk_dev_hold: assert property (
      !pageStepOn_q && !captureCfg |=> $stable(devAddr_q))
      else $error("device address moved without page step");

   chk_dev_step: assert property (
      pageWrap && !captureCfg |=> devAddr_q == $past(devAddr_q) + 7'h01)
      else $error("device address did not step on wrap");

   chk_read_progress: assert property (
      apbSetup && !pwrite && hitProg |=> pready_q && prdata_q == {$past(regsRemaining_q), $past(pointer_q)})
      else $error("progress read data wrong");

   chk_read_inhibit: assert property (
      apbSetup && !pwrite && hitCfg |=> prdata_q[`EBLPT_INHIBIT_BIT] == $past(loadInhibited_q))
      else $error("inhibit bit read wrong");

   chk_timer_clear: assert property (
      finishNow |=> timerRemaining == 16'h0000 && timerPeriod == 16'h0000 ##1 !timerExpired)
      else $error("timer not cleared on completion");

   chk_unmapped_err: assert property (
      apbSetup && !hitAny |=> pready_q && pslverr_q ##1 !pready_q)
      else $error("unmapped access not refused");

   chk_start_once: assert property (
      bootStart && (started_q || loadInhibited_q) && !bootActive_q |=> !bootActive_q)
      else $error("refused boot start took effect");

   chk_inhibit_follow: assert property (
      1'b1 |=> loadInhibited_q == $past(inhibitPin))
      else $error("inhibit flag did not follow pin");

   chk_read_config: assert property (
      apbSetup && !pwrite && hitCfg |=> prdata_q == {$past(bootActive_q), $past(loadInhibited_q),
         $past(pointerWidthSel_q), $past(pageStepOn_q), 21'h0, $past(devAddr_q)})
      else $error("config status read data wrong");

   chk_write_zero: assert property (
      apbSetup && pwrite |=> prdata_q == 32'h00000000)
      else $error("write returned read data");

   chk_ready_pulse: assert property (
      pready_q |=> !pready_q)
      else $error("ready held beyond the access cycle");

   chk_ptr_idle: assert property (
      !bootActive_q |=> $stable(pointer_q))
      else $error("pointer moved while not booting");

   chk_count_idle: assert property (
      state_q == ST_IDLE |=> $stable(regsRemaining_q))
      else $error("count moved while idle");

endmodule : eblpt_tracker

// [eblpt_eeprom_model.sv]
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
module eblpt_eeprom_model (
   input  wire logic        core_clk,
   output logic             byteValid,
   output logic      [7:0]  byteData,
   output logic             pairDone,
   output logic             chainReq,
   output logic      [15:0] chainAddr
);
   logic [7:0]  mem [0:511];
   logic [15:0] readPtr;

   initial begin
      byteValid = 1'b0;
      byteData  = 8'h00;
      pairDone  = 1'b0;
      chainReq  = 1'b0;
      chainAddr = 16'h0000;
      readPtr   = 16'h0000;
      foreach (mem[i]) mem[i] = 8'(i) ^ 8'h5a;
      // Count words stored high byte first
      mem[0]      = 8'h00;
      mem[1]      = 8'h02;
      mem[9'h0f8] = 8'h00;
      mem[9'h0f9] = 8'h01;
   end

   task automatic send_bytes(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge core_clk);
         byteValid <= 1'b1;
         byteData  <= mem[readPtr[8:0]];
         readPtr   <= readPtr + 16'h0001;
      end
      @(posedge core_clk);
      byteValid <= 1'b0;
      // Released data shows the inverse, not a stale copy
      byteData  <= ~byteData;
   endtask : send_bytes

   task automatic finish_pair();
      @(posedge core_clk);
      pairDone <= 1'b1;
      @(posedge core_clk);
      pairDone <= 1'b0;
   endtask : finish_pair

   task automatic chain_to(input logic [15:0] addr);
      @(posedge core_clk);
      chainReq  <= 1'b1;
      chainAddr <= addr;
      readPtr   <= addr & 16'hfff8;
      @(posedge core_clk);
      chainReq  <= 1'b0;
      chainAddr <= ~addr;
   endtask : chain_to
endmodule : eblpt_eeprom_model

// [eeprom_boot_load_progress_tracker_tb.sv]
`timescale 1ns/1ns
`include "eblpt_defs.svh"
//////////////////////////////////////////////////////////////////////////////
module eeprom_boot_load_progress_tracker_tb;
   logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [31:0] paddr, pwdata, prdata;
   logic        bootStart, inhibitPin, ctrlPointerWidth, ctrlPageStep, chainPending;
   logic [6:0]  ctrlDevAddr;
   logic        byteValid, pairDone, chainReq, bootActive, bootTimedOut;
   logic [7:0]  byteData;
   logic [15:0] chainAddr;
   logic [31:0] rd;
   logic        er;
   int          numErrors, totalChecks, n;

   eblpt_tracker #(.TICK_CYCLES(4)) dut (
      .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bootStart(bootStart), .inhibitPin(inhibitPin), .ctrlPointerWidth(ctrlPointerWidth),
      .ctrlPageStep(ctrlPageStep), .ctrlDevAddr(ctrlDevAddr), .chainReq(chainReq),
      .chainAddr(chainAddr), .chainPending(chainPending), .byteValid(byteValid),
      .byteData(byteData), .pairDone(pairDone), .bootActive(bootActive), .bootTimedOut(bootTimedOut));

   eblpt_eeprom_model eep (
      .core_clk(core_clk), .byteValid(byteValid), .byteData(byteData), .pairDone(pairDone),
      .chainReq(chainReq), .chainAddr(chainAddr));

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   //////////////////////////////////////////////////////////////////////////////
   task automatic wrapUp();
      $display("checks %0d errors %0d", totalChecks, numErrors);
      if (numErrors == 0 && totalChecks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : wrapUp

   task automatic expect32(input logic [31:0] got, input logic [31:0] exp, input string what);
      totalChecks++;
      if (got !== exp) begin
         numErrors++;
         $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : expect32

   task automatic apbXfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
      int k;
      @(posedge core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= wdata;
      @(posedge core_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         numErrors++;
         $display("BAD t=%0t no bus answer", $time);
         wrapUp();
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apbXfer

   task automatic rdChk(input logic [31:0] addr, input logic [31:0] mask, input logic [31:0] exp,
                        input logic expErr, input string what);
      apbXfer(1'b0, addr, 32'h0);
      expect32(rd & mask, exp, what);
      expect32({31'h0, er}, {31'h0, expErr}, "slave error");
   endtask : rdChk

   //////////////////////////////////////////////////////////////////////////////
   initial begin
      {rst_n, psel, penable, pwrite, bootStart, inhibitPin} = '0;
      {ctrlPointerWidth, ctrlPageStep, chainPending} = '0;
      {paddr, pwdata, ctrlDevAddr, numErrors, totalChecks} = '0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      rdChk(`EBLPT_PROGRESS_OFS, '1, 32'h0, 1'b0, "progress reset");
      rdChk(`EBLPT_CFG_STATUS_OFS, '1, 32'h0, 1'b0, "cfg reset");
      rdChk(`EBLPT_TIMER_OFS, '1, 32'h00000fa0, 1'b0, "timer reset");
      rdChk(32'h0001d3c0, 32'h0, 32'h0, 1'b1, "unmapped");
      apbXfer(1'b1, `EBLPT_PROGRESS_OFS, 32'hffffffff);
      rdChk(`EBLPT_PROGRESS_OFS, '1, 32'h0, 1'b0, "progress read only");
      inhibitPin <= 1'b1;
      rdChk(`EBLPT_CFG_STATUS_OFS, 32'h40000000, 32'h40000000, 1'b0, "inhibit on");
      inhibitPin <= 1'b0;
      rdChk(`EBLPT_CFG_STATUS_OFS, 32'h40000000, 32'h0, 1'b0, "inhibit off");
      // First EEPROM: count 2, last pair announces a chain
      ctrlPointerWidth <= 1'b1;
      ctrlPageStep     <= 1'b0;
      ctrlDevAddr      <= 7'h50;
      @(posedge core_clk);
      bootStart <= 1'b1;
      @(posedge core_clk);
      bootStart <= 1'b0;
      eep.send_bytes(2);
      rdChk(`EBLPT_PROGRESS_OFS, '1, 32'h00020002, 1'b0, "count loaded");
      rdChk(`EBLPT_CFG_STATUS_OFS, '1, 32'ha0000050, 1'b0, "cfg booting");
      eep.send_bytes(2);
      eep.finish_pair();
      rdChk(`EBLPT_PROGRESS_OFS, '1, 32'h00010004, 1'b0, "first pair");
      chainPending <= 1'b1;
      eep.send_bytes(2);
      eep.finish_pair();
      rdChk(`EBLPT_PROGRESS_OFS, '1, 32'h00000006, 1'b0, "count zero");
      rdChk(`EBLPT_CFG_STATUS_OFS, 32'h80000000, 32'h80000000, 1'b0, "waits for chain");
      // Chain to an unaligned address near a page end
      ctrlPointerWidth <= 1'b0;
      ctrlPageStep     <= 1'b1;
      ctrlDevAddr      <= 7'h2a;
      eep.chain_to(16'h00ff);
      rdChk(`EBLPT_PROGRESS_OFS, 32'h0000ffff, 32'h000000f8, 1'b0, "chain pointer");
      rdChk(`EBLPT_CFG_STATUS_OFS, 32'h3000007f, 32'h1000002a, 1'b0, "width at chain");
      chainPending <= 1'b0;
      eep.send_bytes(2);
      rdChk(`EBLPT_PROGRESS_OFS, '1, 32'h000100fa, 1'b0, "count reloaded");
      eep.send_bytes(6);
      rdChk(`EBLPT_CFG_STATUS_OFS, 32'h0000007f, 32'h0000002b, 1'b0, "device step");
      eep.finish_pair();
      rdChk(`EBLPT_PROGRESS_OFS, '1, 32'h00000100, 1'b0, "load done");
      rdChk(`EBLPT_CFG_STATUS_OFS, '1, 32'h1000002b, 1'b0, "cfg done");
      rdChk(`EBLPT_TIMER_OFS, 32'h0000ffff, 32'h0, 1'b0, "timer cleared");
      // Short timer period: 5 ticks of 4 cycles
      apbXfer(1'b1, `EBLPT_TIMER_OFS, 32'h00000005);
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (bootTimedOut !== 1'b1 && n < 40);
      expect32({31'h0, bootTimedOut}, 32'h1, "timer expiry");
      bootStart <= 1'b1;
      @(posedge core_clk);
      bootStart <= 1'b0;
      rdChk(`EBLPT_CFG_STATUS_OFS, 32'h80000000, 32'h0, 1'b0, "idle after expiry");
      // Mid-run reset with boot disabled: the start must be refused
      rst_n <= 1'b0;
      @(posedge core_clk);
      rst_n      <= 1'b1;
      inhibitPin <= 1'b1;
      @(posedge core_clk);
      bootStart <= 1'b1;
      @(posedge core_clk);
      bootStart <= 1'b0;
      rdChk(`EBLPT_CFG_STATUS_OFS, '1, 32'h40000000, 1'b0, "inhibited start");
      rdChk(`EBLPT_PROGRESS_OFS, '1, 32'h0, 1'b0, "progress after reset");
      wrapUp();
   end
endmodule : eeprom_boot_load_progress_tracker_tb
